// file: hw/ascr_link.sv
`timescale 1ns/1ps

module ascr_link (
  input  wire logic                          link_sck_in,
  input  wire logic                          cfg_clr_in,
  input  wire logic                          rd_clr_in,
  input  wire logic                          cfg_din_in,
  input  wire logic                          busy_mode_in,
  input  wire logic [ascr_pkg::RES_W-1:0]    result_in,
  output logic      [ascr_pkg::CFG_W-1:0]    cfg_word_out,
  output logic                               cfg_done_out,
  output logic                               out_run_out,
  output logic                               out_bit_out
);

  logic [ascr_pkg::CFG_CNT_W-1:0] cfg_cnt;
  logic [ascr_pkg::OUT_CNT_W-1:0] out_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration shift, MSB first on rising edges, frozen after fourteen.
  always_ff @(posedge link_sck_in or posedge cfg_clr_in) begin
    if (cfg_clr_in) begin
      cfg_cnt      <= ascr_pkg::CFG_ZERO;
      cfg_word_out <= ascr_pkg::CFG_RESET;
      cfg_done_out <= 1'b0;
    end else if (!cfg_done_out) begin
      cfg_cnt      <= cfg_cnt + 4'h1;
      cfg_word_out <= {cfg_word_out[ascr_pkg::CFG_W-2:0], cfg_din_in};
      cfg_done_out <= (cfg_cnt == ascr_pkg::CFG_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback advances on falling edges until the float point.
  wire [4:0] out_end = busy_mode_in ? ascr_pkg::OUT_END_BUSY
                                    : ascr_pkg::OUT_END_PLAIN;
  wire       start_bit = busy_mode_in && (out_cnt == ascr_pkg::OUT_ZERO);
  wire [4:0] out_idx   = busy_mode_in ? (out_cnt - 5'h01) : out_cnt;
  wire [4:0] bit_pos   = ascr_pkg::OUT_MSB - out_idx;
  wire       in_range  = (out_idx <= ascr_pkg::OUT_MSB);

  assign out_run_out = (out_cnt < out_end);
  assign out_bit_out = (!start_bit && in_range) ? result_in[bit_pos[3:0]]
                                                 : 1'b0;

  always_ff @(negedge link_sck_in or posedge rd_clr_in) begin
    if (rd_clr_in) begin
      out_cnt <= ascr_pkg::OUT_ZERO;
    end else if (out_run_out) begin
      out_cnt <= out_cnt + 5'h01;
    end
  end

endmodule : ascr_link

// file: hw/ascr_pkg.sv
package ascr_pkg;

  // System clock period and the longest conversion_time in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_CONV_MAX_NS = 4000;

  // Longest time rounds down to whole cycles, never below one cycle.
  localparam int unsigned CONV_CYC_RAW = T_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC     = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;

  // Conversion timer layout.
  localparam int          TMR_W     = 12;
  localparam logic [11:0] TMR_LOAD  = 12'(CONV_CYC);
  localparam logic [11:0] TMR_LAST  = 12'h001;
  localparam logic [11:0] TMR_ZERO  = 12'h000;

  // Result word and configuration word layout.
  localparam int          RES_W     = 16;
  localparam int          CFG_W     = 14;
  localparam int          CFG_FLAG  = 13;
  localparam logic [13:0] CFG_RESET = 14'h0000;
  localparam logic [15:0] RES_RESET = 16'h0000;

  // Configuration bit counter: fourteen rising edges, last index 13.
  localparam int          CFG_CNT_W = 4;
  localparam logic [3:0]  CFG_LAST  = 4'hd;
  localparam logic [3:0]  CFG_ZERO  = 4'h0;

  // Readback falling-edge counter and its float points.
  localparam int          OUT_CNT_W = 5;
  localparam logic [4:0]  OUT_END_PLAIN = 5'h10;
  localparam logic [4:0]  OUT_END_BUSY  = 5'h11;
  localparam logic [4:0]  OUT_ZERO      = 5'h00;
  localparam logic [4:0]  OUT_MSB       = 5'h0f;

  // Converter states, Gray coded along acquire, convert, read.
  typedef enum logic [1:0] {
    ASCR_ACQ  = 2'b00,
    ASCR_CONV = 2'b01,
    ASCR_READ = 2'b11
  } ascr_state_t;

endpackage : ascr_pkg

// file: hw/ascr_top.sv
// How it works
// - Start edge begins conversion, floats output
// - Running conversion ignores later start-pin edges; the level at its end picks the mode
// - Clock high at start edge arms configuration
// - Fourteen config bits, MSB first, rising edges
// - Config loaded during conversion applies at end
// - Config loaded during readback applies one later
// - Conversion end enters acquisition (readback in busy mode), powers down
// - Plain mode: start pin fall shows MSB
// - Each falling clock edge advances result bit
// - Bits stay valid across the rising clock edge
// - Plain mode floats after 16th fall or start
// - Busy mode: output floats during conversion
// - Busy mode: output driven at conversion end
// - Busy mode floats after 17th fall or start
// - Reads during conversion see the floated output, not the held result
// - Config input ignored after fourteenth clock
`timescale 1ns/1ps

module ascr_top (
  input  wire logic                        sys_clk_in,
  input  wire logic                        reset_in,
  input  wire logic                        link_sck_in,
  input  wire logic                        conversion_start_pin_in,
  input  wire logic                        cfg_din_in,
  input  wire logic [ascr_pkg::RES_W-1:0]  sample_code_in,
  output logic                             result_serial_output_out,
  output logic                             result_serial_output_oe_out,
  output logic                             conv_power_out,
  output logic                             conv_done_out,
  output logic                             busy_mode_out,
  output logic      [ascr_pkg::CFG_W-1:0]  active_cfg_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ascr_pkg::ascr_state_t state;
  ascr_pkg::ascr_state_t next_state;

  logic [1:0]                    pin_meta;
  logic [1:0]                    pin_sync;
  logic                          pin_prev;
  logic                          done_meta;
  logic                          done_sync;
  logic                          done_prev;
  logic [ascr_pkg::TMR_W-1:0]    timer;
  logic                          armed;
  logic                          cfg_clr;
  logic                          rd_clr;
  logic                          pend_valid;
  logic [ascr_pkg::CFG_W-1:0]    pend_word;
  logic [ascr_pkg::RES_W-1:0]    result;
  logic [ascr_pkg::TMR_W-1:0]    conv_len;

  logic [ascr_pkg::CFG_W-1:0]    link_cfg_word;
  logic                          link_cfg_done;
  logic                          link_out_run;
  logic                          link_out_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the start pin and the serial clock level.
  wire [1:0] pin_raw = {link_sck_in, conversion_start_pin_in};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[0];
    end
  end

  // Edges and levels of the synchronised pins.
  wire pin_level = pin_sync[0];
  wire sck_level = pin_sync[1];
  wire pin_rise  = pin_level && !pin_prev;
  wire pin_fall  = !pin_level && pin_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag of a configuration load crosses in from the link side.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      done_meta <= link_cfg_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  // The word is frozen once the flag is high, so it is sampled as is.
  wire cfg_taken = done_sync && !done_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode for the converter.
  wire in_conv    = (state == ascr_pkg::ASCR_CONV);
  wire in_read    = (state == ascr_pkg::ASCR_READ);
  wire in_acq     = (state == ascr_pkg::ASCR_ACQ);
  wire conv_end   = in_conv && (timer == ascr_pkg::TMR_LAST);
  wire start      = pin_rise && !in_conv;
  wire busy_end   = conv_end && !pin_level;
  wire plain_read = pin_fall && in_acq;
  wire read_start = busy_end || plain_read;

  // A word is kept when its write flag is set and it arrived in a window.
  wire arm_window = in_conv && armed;
  wire cfg_keep   = cfg_taken && link_cfg_word[ascr_pkg::CFG_FLAG]
                    && (arm_window || in_read);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; a running conversion ignores start-pin edges.
  always_comb begin
    next_state = state;
    case (state)
      ascr_pkg::ASCR_ACQ: begin
        if (start) begin
          next_state = ascr_pkg::ASCR_CONV;
        end else if (plain_read) begin
          next_state = ascr_pkg::ASCR_READ;
        end
      end
      ascr_pkg::ASCR_CONV: begin
        if (busy_end) begin
          next_state = ascr_pkg::ASCR_READ;
        end else if (conv_end) begin
          next_state = ascr_pkg::ASCR_ACQ;
        end
      end
      ascr_pkg::ASCR_READ: begin
        if (start) begin
          next_state = ascr_pkg::ASCR_CONV;
        end
      end
      default: begin
        next_state = ascr_pkg::ASCR_ACQ;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= ascr_pkg::ASCR_ACQ;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer runs the full longest conversion_time once started.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      timer <= ascr_pkg::TMR_ZERO;
    end else if (start) begin
      timer <= ascr_pkg::TMR_LOAD;
    end else if (in_conv) begin
      timer <= timer - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Config counter is cleared at conversion and readback start; readback counter at readback start.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cfg_clr <= 1'b1;
      rd_clr  <= 1'b1;
    end else begin
      cfg_clr <= start || read_start;
      rd_clr  <= read_start;
    end
  end

  // Serial clock high at the start edge arms a load for this conversion.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      armed <= 1'b0;
    end else if (start) begin
      armed <= sck_level;
    end else if (conv_end) begin
      armed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending word; a new word wins over the clear at conversion end.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pend_valid <= 1'b0;
      pend_word  <= ascr_pkg::CFG_RESET;
    end else if (cfg_keep) begin
      pend_valid <= 1'b1;
      pend_word  <= link_cfg_word;
    end else if (conv_end) begin
      pend_valid <= 1'b0;
    end
  end

  // Active configuration changes only at the end of a conversion.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      active_cfg_out <= ascr_pkg::CFG_RESET;
    end else if (conv_end && pend_valid) begin
      active_cfg_out <= pend_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and mode are taken at conversion end, so the previous word is
  // held while converting; the output floats then, so a read sees no data.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      result        <= ascr_pkg::RES_RESET;
      busy_mode_out <= 1'b0;
      conv_done_out <= 1'b0;
    end else begin
      conv_done_out <= conv_end;
      if (conv_end) begin
        result        <= sample_code_in;
        busy_mode_out <= !pin_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine on the link clock.
  ascr_link u_link (
    .link_sck_in  (link_sck_in),
    .cfg_clr_in   (cfg_clr),
    .rd_clr_in    (rd_clr),
    .cfg_din_in   (cfg_din_in),
    .busy_mode_in (busy_mode_out),
    .result_in    (result),
    .cfg_word_out (link_cfg_word),
    .cfg_done_out (link_cfg_done),
    .out_run_out  (link_out_run),
    .out_bit_out  (link_out_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output drive: only in readback, after the clear, before the float point.
  assign result_serial_output_oe_out = in_read && !rd_clr
                                       && link_out_run;
  assign result_serial_output_out    = link_out_bit;
  assign conv_power_out              = in_conv;

  ////////////////////////////////////////////////////////////////////////////
  // Helper counter of cycles spent converting.
  localparam logic [11:0] CONV_LEN_CHK = ascr_pkg::TMR_LOAD - 12'h001;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      conv_len <= ascr_pkg::TMR_ZERO;
    end else if (in_conv) begin
      conv_len <= conv_len + 12'h001;
    end else begin
      conv_len <= ascr_pkg::TMR_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  start_float_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    start |=> in_conv && !result_serial_output_oe_out)
    else $error("Start edge did not begin a floating conversion.");

  conv_runs_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    conv_end |-> conv_len == CONV_LEN_CHK)
    else $error("Conversion did not last the full conversion time.");

  arm_level_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    start |=> armed == $past(sck_level))
    else $error("Configuration arm does not follow the clock level.");

  cfg_apply_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    conv_end && pend_valid |=> active_cfg_out == $past(pend_word))
    else $error("Pending configuration not applied at conversion end.");

  cfg_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    !conv_end |=> $stable(active_cfg_out))
    else $error("Active configuration changed outside conversion end.");

  acq_power_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    conv_end |=> !conv_power_out && conv_done_out)
    else $error("Converter stayed powered after conversion end.");

  plain_msb_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    $rose(result_serial_output_oe_out) && !busy_mode_out
    |-> result_serial_output_out == result[ascr_pkg::RES_W-1])
    else $error("First driven bit in plain mode is not the MSB.");

  start_cut_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    in_read && pin_rise |=> !result_serial_output_oe_out)
    else $error("Output still driven after a start edge.");

  busy_float_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    in_conv |-> !result_serial_output_oe_out)
    else $error("Output driven while converting.");

  busy_drive_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    busy_end |=> in_read && busy_mode_out && rd_clr)
    else $error("Busy mode did not enter readback at conversion end.");

  busy_start_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    $rose(result_serial_output_oe_out) && busy_mode_out
    |-> !result_serial_output_out)
    else $error("Busy mode readback did not open with the start bit.");

  prev_result_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    in_conv && !conv_end |=> $stable(result))
    else $error("Result changed during a conversion.");

  cfg_ignore_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    in_conv && !cfg_keep |=> $stable(pend_word))
    else $error("Configuration accepted outside a load.");

  read_open_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    plain_read |-> ##2 result_serial_output_oe_out)
    else $error("Plain readback did not drive the output in time.");

  done_pulse_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    conv_done_out |=> !conv_done_out)
    else $error("Conversion done pulse lasted more than one cycle.");

endmodule : ascr_top

// file: test/ascr_host_model.sv
`timescale 1ns/1ps

// Host side: drives the start pin, bursts of serial clock and the
// configuration data, and captures the result line it sees.
module ascr_host_model (
  input  wire logic clk_in,
  input  wire logic res_line_in,
  output logic      start_pin_out,
  output logic      sck_out,
  output logic      din_out
);

  // The serial clock parks low between bursts, or high to arm a load, so it never runs free.
  initial begin
    start_pin_out = 1'b0;
    sck_out       = 1'b0;
    din_out       = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////

  // Starts a conversion; the clock is parked high when a load is wanted.
  task automatic start_conv(input logic arm, input logic busy);
    sck_out = arm;
    #100;
    @(negedge clk_in);
    start_pin_out = 1'b1;
    repeat (12) @(negedge clk_in);
    start_pin_out = 1'b0;
    if (!busy) begin
      repeat (2) @(negedge clk_in);
      start_pin_out = 1'b1;
    end
  endtask : start_conv

  // Moves the start pin at a system clock falling edge.
  task automatic set_pin(input logic level);
    @(negedge clk_in);
    start_pin_out = level;
  endtask : set_pin

  // Shifts sixteen bits MSB first on rising edges; the last two are extra.
  task automatic load_cfg(input logic [15:0] word);
    sck_out = 1'b0;
    #6;
    for (int i = 0; i < 16; i++) begin
      din_out = word[15-i];
      #6;
      sck_out = 1'b1;
      #6;
      sck_out = 1'b0;
    end
    din_out = 1'b0;
  endtask : load_cfg

  // Captures each bit just before the rising edge, then lets it advance.
  task automatic read_bits(input int n, input logic [15:0] word,
                           output logic [16:0] cap);
    cap = 17'h00000;
    for (int i = 0; i < n; i++) begin
      din_out = (i < 16) ? word[15-i] : 1'b0;
      #6;
      cap = {cap[15:0], res_line_in};
      sck_out = 1'b1;
      #6;
      sck_out = 1'b0;
    end
    din_out = 1'b0;
    #6;
  endtask : read_bits

endmodule : ascr_host_model

// file: test/test_adc_serial_convert_readback.sv
`timescale 1ns/1ps

module test_adc_serial_convert_readback;

  logic        sys_clk_in;
  logic        reset_in;
  logic        pin;
  logic        sck;
  logic        din;
  logic [15:0] sample;
  logic        res_bit;
  logic        res_oe;
  logic        res_line;
  logic        power;
  logic        done;
  logic        busy;
  logic [13:0] cfg;
  int          n_mismatch;
  int          total_checks;
  int          conv_run;
  int          conv_last;

  // The result line carries a pull-up, so a floating output reads high.
  assign res_line = res_oe ? res_bit : 1'b1;

  ascr_top dut_u (
    .sys_clk_in                  (sys_clk_in),
    .reset_in                    (reset_in),
    .link_sck_in                 (sck),
    .conversion_start_pin_in     (pin),
    .cfg_din_in                  (din),
    .sample_code_in              (sample),
    .result_serial_output_out    (res_bit),
    .result_serial_output_oe_out (res_oe),
    .conv_power_out              (power),
    .conv_done_out               (done),
    .busy_mode_out               (busy),
    .active_cfg_out              (cfg)
  );

  ascr_host_model host_u (
    .clk_in        (sys_clk_in),
    .res_line_in   (res_line),
    .start_pin_out (pin),
    .sck_out       (sck),
    .din_out       (din)
  );

  // System clock, 20 ns period.
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // Counts powered cycles of each conversion; the length is kept at its end.
  always @(posedge sys_clk_in) begin
    if (power === 1'b1) begin
      conv_run <= conv_run + 1;
    end else if (conv_run != 0) begin
      conv_last <= conv_run;
      conv_run  <= 0;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Compare tasks for flags and for words.
  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check_flag

  task automatic check_word(input string name, input logic [15:0] exp,
                            input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // Waits out a conversion and checks its length and quiet output.
  task automatic wait_conv(input logic exp_busy, input logic [13:0] exp_cfg);
    int   k;
    int   cyc;
    logic oe_seen;
    k = 0;
    cyc = 0;
    oe_seen = 1'b0;
    while (power !== 1'b1 && k < 40) begin
      @(negedge sys_clk_in);
      k++;
    end
    while (power === 1'b1 && cyc < 400) begin
      oe_seen = oe_seen | res_oe;
      @(negedge sys_clk_in);
      cyc++;
    end
    check_flag("oe_in_conv", 1'b0, oe_seen);
    check_flag("conv_done", 1'b1, done);
    // Readback drive follows the clear pulse, one cycle after the end.
    @(negedge sys_clk_in);
    check_flag("done_pulse", 1'b0, done);
    check_word("conv_cycles", 16'(ascr_pkg::CONV_CYC),
               16'(conv_last));
    check_flag("busy_mode", exp_busy, busy);
    check_flag("oe_at_end", exp_busy, res_oe);
    check_word("active_cfg", {2'b00, exp_cfg}, {2'b00, cfg});
  endtask : wait_conv

  // Drops the pin in acquisition and waits for the output to drive.
  task automatic open_read();
    int k;
    k = 0;
    host_u.set_pin(1'b0);
    while (res_oe !== 1'b1 && k < 20) begin
      @(negedge sys_clk_in);
      k++;
    end
    check_flag("oe_on_read", 1'b1, res_oe);
    #60;
  endtask : open_read

  //////////////////////////////////////////////////////////////////////////

  // Load during conversion with two extra bits, then a readback that
  // carries a second word for the conversion after next.
  task automatic test_cfg_in_conv();
    logic [16:0] cap;
    @(negedge sys_clk_in);
    sample = 16'ha5c3;
    host_u.start_conv(1'b1, 1'b0);
    host_u.load_cfg(16'hc9b3);
    wait_conv(1'b0, 14'h326c);
    open_read();
    host_u.read_bits(16, 16'he1d4, cap);
    check_word("plain_result", sample, cap[15:0]);
    check_flag("oe_after_16", 1'b0, res_oe);
  endtask : test_cfg_in_conv

  // The word loaded in the last readback is applied at the end of this
  // unarmed conversion, so it governs the conversion after it.
  task automatic test_cfg_in_read();
    logic [16:0] cap;
    @(negedge sys_clk_in);
    sample = 16'h8001;
    host_u.start_conv(1'b0, 1'b0);
    wait_conv(1'b0, 14'h3875);
    open_read();
    host_u.read_bits(16, 16'h0000, cap);
    check_word("plain_edges", sample, cap[15:0]);
  endtask : test_cfg_in_read

  // Busy indication: start bit, sixteen bits, float after the 17th fall.
  task automatic test_busy();
    logic [16:0] cap;
    @(negedge sys_clk_in);
    sample = 16'h7ffe;
    host_u.start_conv(1'b0, 1'b1);
    wait_conv(1'b1, 14'h3875);
    #60;
    host_u.read_bits(17, 16'h0000, cap);
    check_flag("start_bit", 1'b0, cap[16]);
    check_word("busy_result", sample, cap[15:0]);
    check_flag("oe_after_17", 1'b0, res_oe);
  endtask : test_busy

  // A start edge in mid-readback floats the output and converts again.
  task automatic test_abort();
    logic [16:0] cap;
    @(negedge sys_clk_in);
    sample = 16'h3c3c;
    host_u.start_conv(1'b0, 1'b0);
    wait_conv(1'b0, 14'h3875);
    open_read();
    host_u.read_bits(4, 16'h0000, cap);
    check_word("part_result", 16'h0003, {12'h000, cap[3:0]});
    #60;
    host_u.set_pin(1'b1);
    repeat (6) @(negedge sys_clk_in);
    check_flag("oe_after_rise", 1'b0, res_oe);
    wait_conv(1'b0, 14'h3875);
  endtask : test_abort

  //////////////////////////////////////////////////////////////////////////

  // Main sequence: reset for five cycles, then the scenarios.
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    reset_in = 1'b1;
    sample = 16'h0000;
    repeat (5) @(negedge sys_clk_in);
    reset_in = 1'b0;
    check_flag("oe_reset", 1'b0, res_oe);
    test_cfg_in_conv();
    test_cfg_in_read();
    test_busy();
    test_abort();
    summarize();
  end

  // Watchdog well beyond the few conversions the run needs.
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

endmodule : test_adc_serial_convert_readback
